// file: emx_mem_op_exec.sv
// memory-op execute unit with accumulator, flags and AXI4-Lite access
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "emx_regs.svh"

module emx_mem_op_exec #(
	parameter int ADDR_W = 8 // data memory address width
) (
	input  wire logic              clk,       // core clock
	input  wire logic              reset,     // sync reset, active high
	input  wire logic              opValid,   // sequencer offers an op
	input  emx_pkg::emx_req_t      opReq,     // op, bit and memory byte
	input  wire logic [ADDR_W-1:0] opAddr,    // memory address of op
	output logic                   opReady,   // unit accepts an op
	output logic                   opDone,    // op finished, pulse
	output logic                   skipTaken, // next op is skipped, pulse
	output logic                   dummyCycle,// inserted dummy cycle
	output logic                   memWrEn,   // memory write strobe
	output logic [ADDR_W-1:0]      memWrAddr, // memory write address
	output logic [7:0]             memWrData, // memory write data
	output logic [7:0]             accumulator, // accumulator
	output emx_pkg::emx_flags_t    flags,     // status flags
	input  wire logic              awvalid,   // AXI write address valid
	output logic                   awready,   // AXI write address ready
	input  wire logic [7:0]        awaddr,    // AXI write address
	input  wire logic              wvalid,    // AXI write data valid
	output logic                   wready,    // AXI write data ready
	input  wire logic [31:0]       wdata,     // AXI write data
	input  wire logic [3:0]        wstrb,     // AXI write strobes
	output logic                   bvalid,    // AXI write response valid
	input  wire logic              bready,    // AXI write response ready
	output logic [1:0]             bresp,     // AXI write response
	input  wire logic              arvalid,   // AXI read address valid
	output logic                   arready,   // AXI read address ready
	input  wire logic [7:0]        araddr,    // AXI read address
	output logic                   rvalid,    // AXI read data valid
	input  wire logic              rready,    // AXI read data ready
	output logic [31:0]            rdata,     // AXI read data
	output logic [1:0]             rresp      // AXI read response
);

	////////////////////////////////////////////////////////////////////
	// execute stage

	logic                taken;
	logic [7:0]          exResult;
	logic                exToAcc;
	logic                exToMem;
	emx_pkg::emx_flags_t exFlags;
	logic                exSkip;
	emx_pkg::emx_state_t state;
	logic [15:0]         skipCount;

	assign taken = opValid && opReady;

	emx_exec_unit u_exec (
		.req      (opReq),
		.acc      (accumulator),
		.flagsIn  (flags),
		.result   (exResult),
		.toAcc    (exToAcc),
		.toMem    (exToMem),
		.flagsOut (exFlags),
		.skip     (exSkip)
	);

	////////////////////////////////////////////////////////////////////
	// sequencing: a taken skip costs one dummy cycle

	always_ff @(posedge clk)
	begin
		if (reset)
			state <= emx_pkg::ST_RUN;
		else
			case (state)
				emx_pkg::ST_RUN:
					if (taken && exSkip)
						state <= emx_pkg::ST_DUMMY;
				emx_pkg::ST_DUMMY:
					state <= emx_pkg::ST_RUN;
				default:
					state <= emx_pkg::ST_RUN;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			opReady <= 1'b1;
			dummyCycle <= 1'b0;
			opDone <= 1'b0;
			skipTaken <= 1'b0;
		end
		else
		begin
			// untaken skip keeps the pipe open
			opReady <= !(taken && exSkip);
			dummyCycle <= taken && exSkip;
			opDone <= taken;
			skipTaken <= taken && exSkip;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			memWrEn <= 1'b0;
			memWrAddr <= '0;
			memWrData <= 8'h00;
		end
		else
		begin
			memWrEn <= taken && exToMem;
			if (taken && exToMem)
			begin
				memWrAddr <= opAddr;
				memWrData <= exResult;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// register bus: write channel

	logic       awHeld;
	logic       wHeld;
	logic [7:0] awAddrQ;
	logic [7:0] wDataQ;
	logic       wLaneQ;
	logic       doWrite;

	assign doWrite = awHeld && wHeld && !bvalid;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			awHeld <= 1'b0;
			awready <= 1'b1;
			awAddrQ <= 8'h00;
		end
		else if (awvalid && awready)
		begin
			awHeld <= 1'b1;
			awready <= 1'b0;
			awAddrQ <= awaddr;
		end
		else if (doWrite)
		begin
			awHeld <= 1'b0;
			awready <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wHeld <= 1'b0;
			wready <= 1'b1;
			wDataQ <= 8'h00;
			wLaneQ <= 1'b0;
		end
		else if (wvalid && wready)
		begin
			wHeld <= 1'b1;
			wready <= 1'b0;
			wDataQ <= wdata[7:0];
			wLaneQ <= wstrb[0];
		end
		else if (doWrite)
		begin
			wHeld <= 1'b0;
			wready <= 1'b1;
		end
	end

	logic swAcc;
	logic swFlags;
	logic wMapped;

	assign wMapped = (awAddrQ == `EMX_OFS_ACC) ||
		(awAddrQ == `EMX_OFS_FLAGS) || (awAddrQ == `EMX_OFS_SKIPS);
	assign swAcc = doWrite && wLaneQ && (awAddrQ == `EMX_OFS_ACC);
	assign swFlags = doWrite && wLaneQ && (awAddrQ == `EMX_OFS_FLAGS);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bvalid <= 1'b0;
			bresp <= `EMX_RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid <= 1'b1;
			bresp <= wMapped ? `EMX_RESP_OKAY : `EMX_RESP_SLVERR;
		end
		else if (bvalid && bready)
			bvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// accumulator and flags: an executing op wins over software

	always_ff @(posedge clk)
	begin
		if (reset)
			accumulator <= `EMX_ACC_RESET;
		else if (taken && exToAcc)
			accumulator <= exResult;
		else if (swAcc)
			accumulator <= wDataQ;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			flags <= `EMX_FLAGS_RESET;
		else if (taken)
			flags <= exFlags;
		else if (swFlags)
			flags <= wDataQ[5:0];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			skipCount <= 16'h0000;
		else if (taken && exSkip)
			skipCount <= skipCount + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////
	// register bus: read channel

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `EMX_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= `EMX_RESP_OKAY;
			case (araddr)
				`EMX_OFS_ACC:   rdata <= {24'h000000, accumulator};
				`EMX_OFS_FLAGS: rdata <= {26'h0, flags};
				`EMX_OFS_SKIPS: rdata <= {16'h0000, skipCount};
				default:
				begin
					rdata <= 32'h0000_0000;
					rresp <= `EMX_RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_skipTake;
		taken && exSkip;
	endsequence

	sequence s_dummyThenRun;
		(dummyCycle && !opReady) ##1 (opReady && !dummyCycle);
	endsequence

	property p_rotLeftCarry;
		taken && opReq.op == emx_pkg::OP_ROT_LEFT_CARRY_TO_ACC |=>
			accumulator == {$past(opReq.mem[6:0]), $past(flags.carry)} &&
			flags.carry == $past(opReq.mem[7]) && !memWrEn;
	endproperty
	a_rotLeftCarry: assert property (p_rotLeftCarry)
		else $error("left rotate through carry wrong");

	property p_rotRightMem;
		taken && opReq.op == emx_pkg::OP_ROT_RIGHT_MEM |=>
			memWrEn && memWrData == {$past(opReq.mem[0]),
			$past(opReq.mem[7:1])} && flags == $past(flags);
	endproperty
	a_rotRightMem: assert property (p_rotRightMem)
		else $error("right rotate in place wrong");

	property p_rotRightCarryMem;
		taken && !swAcc &&
			opReq.op == emx_pkg::OP_ROT_RIGHT_CARRY_MEM |=>
			memWrData == {$past(flags.carry), $past(opReq.mem[7:1])} &&
			flags.carry == $past(opReq.mem[0]) &&
			accumulator == $past(accumulator);
	endproperty
	a_rotRightCarryMem: assert property (p_rotRightCarryMem)
		else $error("right rotate through carry wrong");

	property p_subBorrow;
		taken && opReq.op == emx_pkg::OP_SUB_BORROW_TO_ACC |=>
			accumulator == 8'($past(accumulator) - $past(opReq.mem) -
			{7'h00, !$past(flags.carry)}) &&
			flags.zero == (accumulator == 8'h00);
	endproperty
	a_subBorrow: assert property (p_subBorrow)
		else $error("subtract with borrow wrong");

	property p_subCarry;
		taken && opReq.op == emx_pkg::OP_SUB_TO_MEM |=>
			memWrEn && flags.carry ==
			($past(accumulator) >= $past(opReq.mem));
	endproperty
	a_subCarry: assert property (p_subCarry)
		else $error("subtract carry wrong");

	property p_skipDummy;
		s_skipTake |=> s_dummyThenRun;
	endproperty
	a_skipDummy: assert property (p_skipDummy)
		else $error("taken skip did not insert one dummy cycle");

	property p_noSkipOneCycle;
		taken && !exSkip |=> opReady && !dummyCycle && !skipTaken;
	endproperty
	a_noSkipOneCycle: assert property (p_noSkipOneCycle)
		else $error("untaken skip stalled the unit");

	property p_decSkip;
		taken && opReq.op == emx_pkg::OP_DEC_SKIP_ZERO |=>
			memWrEn && memWrData == 8'($past(opReq.mem) - 8'h01) &&
			skipTaken == ($past(opReq.mem) == 8'h01) &&
			flags == $past(flags);
	endproperty
	a_decSkip: assert property (p_decSkip)
		else $error("decrement and skip wrong");

	property p_setByte;
		taken && opReq.op == emx_pkg::OP_SET_MEM_BITS |=>
			memWrEn && memWrData == `EMX_BYTE_ONES &&
			memWrAddr == $past(opAddr);
	endproperty
	a_setByte: assert property (p_setByte)
		else $error("byte set wrong");

	property p_skipZero;
		taken && !swAcc && opReq.op == emx_pkg::OP_SKIP_ZERO |=>
			!memWrEn && skipTaken == ($past(opReq.mem) == 8'h00) &&
			accumulator == $past(accumulator);
	endproperty
	a_skipZero: assert property (p_skipZero)
		else $error("zero skip changed state or misjudged");

	property p_dummyState;
		dummyCycle == (state == emx_pkg::ST_DUMMY) &&
			opReady == (state == emx_pkg::ST_RUN);
	endproperty
	a_dummyState: assert property (p_dummyState)
		else $error("dummy cycle out of step with sequencer state");

endmodule // emx_mem_op_exec

// file: emx_regs.svh
// register offsets, field positions and reset values of the memory-op unit
//
// How it works
// - rotate left via carry into accumulator only
// - rotate memory right in place, no flags
// - rotate right into accumulator, memory kept
// - rotate right via carry in place, carry
// - rotate right via carry into accumulator
// - subtract with borrow into accumulator, six flags
// - subtract with borrow into memory, same flags
// - plain subtract to accumulator or memory
// - taken skip adds one dummy cycle
// - decrement memory, skip when result zero
// - decrement into accumulator, skip when zero
// - increment memory, skip when result zero
// - increment into accumulator, skip when zero
// - byte set writes all ones
// - bit set forces one selected bit
// - skip when selected bit is one
// - skip when whole byte is nonzero
// - nibble exchange in place or to accumulator
// - skip when byte is zero, nothing changes
// - copy to accumulator, skip when zero
// - skip when selected bit is zero
`ifndef EMX_REGS_SVH
`define EMX_REGS_SVH

`define EMX_OFS_ACC      8'h00
`define EMX_OFS_FLAGS    8'h04
`define EMX_OFS_SKIPS    8'h08

`define EMX_FLAG_CARRY      0
`define EMX_FLAG_AUX_CARRY  1
`define EMX_FLAG_ZERO       2
`define EMX_FLAG_OVERFLOW   3
`define EMX_FLAG_SIGNED_CMP 4
`define EMX_FLAG_CMP_ZERO   5

`define EMX_ACC_RESET    8'h00
`define EMX_FLAGS_RESET  6'h00
`define EMX_BYTE_ONES    8'hFF

`define EMX_RESP_OKAY    2'h0
`define EMX_RESP_SLVERR  2'h2

`endif

// file: emx_pkg.sv
// types shared by the memory-op unit
package emx_pkg;

	typedef enum logic [4:0] {
		OP_ROT_LEFT_CARRY_TO_ACC,
		OP_ROT_RIGHT_MEM,
		OP_ROT_RIGHT_TO_ACC,
		OP_ROT_RIGHT_CARRY_MEM,
		OP_ROT_RIGHT_CARRY_TO_ACC,
		OP_SUB_BORROW_TO_ACC,
		OP_SUB_BORROW_TO_MEM,
		OP_SUB_TO_ACC,
		OP_SUB_TO_MEM,
		OP_DEC_SKIP_ZERO,
		OP_DEC_SKIP_ZERO_TO_ACC,
		OP_INC_SKIP_ZERO,
		OP_INC_SKIP_ZERO_TO_ACC,
		OP_SET_MEM_BITS,
		OP_SET_MEM_BIT,
		OP_SKIP_NONZERO_BIT,
		OP_SKIP_NONZERO,
		OP_NIBBLE_EXCHANGE,
		OP_NIBBLE_EXCHANGE_TO_ACC,
		OP_SKIP_ZERO,
		OP_MOVE_SKIP_ZERO,
		OP_SKIP_ZERO_BIT
	} emx_op_t;

	typedef struct packed {
		logic compareZero;
		logic signedCompare;
		logic overflow;
		logic zero;
		logic auxCarry;
		logic carry;
	} emx_flags_t;

	typedef struct packed {
		emx_op_t    op;
		logic [2:0] bitSel;
		logic [7:0] mem;
	} emx_req_t;

	typedef enum logic {ST_RUN, ST_DUMMY} emx_state_t;

endpackage

// file: emx_exec_unit.sv
// combinational execute stage of the memory-op unit
`timescale 1ns/1ps
`include "emx_regs.svh"

module emx_exec_unit (
	input  emx_pkg::emx_req_t   req,     // operation and memory byte
	input  wire logic [7:0]     acc,     // current accumulator
	input  emx_pkg::emx_flags_t flagsIn, // current flags
	output logic [7:0]          result,  // computed byte
	output logic                toAcc,   // result goes to accumulator
	output logic                toMem,   // result goes to memory
	output emx_pkg::emx_flags_t flagsOut,// flags after the op
	output logic                skip     // next instruction is skipped
);

	function automatic logic [7:0] bitMask(input logic [2:0] i);
		bitMask = 8'h01 << i;
	endfunction

	logic [7:0] m;
	logic       useBorrow;
	logic       cin;
	logic [8:0] diff9;
	logic [4:0] low5;
	logic [7:0] dec;
	logic [7:0] inc;
	logic       ov;

	assign m = req.mem;
	assign useBorrow = (req.op == emx_pkg::OP_SUB_BORROW_TO_ACC) ||
		(req.op == emx_pkg::OP_SUB_BORROW_TO_MEM);
	assign cin = useBorrow ? flagsIn.carry : 1'b1;
	// a - m - !c as a + ~m + c; carry out means no borrow
	assign diff9 = {1'b0, acc} + {1'b0, ~m} + {8'h00, cin};
	assign low5 = {1'b0, acc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cin};
	assign ov = (acc[7] ^ m[7]) & (acc[7] ^ diff9[7]);
	assign dec = m - 8'h01;
	assign inc = m + 8'h01;

	always_comb
	begin
		result = m;
		toAcc = 1'b0;
		toMem = 1'b0;
		skip = 1'b0;
		flagsOut = flagsIn;
		case (req.op)
			emx_pkg::OP_ROT_LEFT_CARRY_TO_ACC:
			begin
				result = {m[6:0], flagsIn.carry};
				toAcc = 1'b1;
				flagsOut.carry = m[7];
			end
			emx_pkg::OP_ROT_RIGHT_MEM:
			begin
				result = {m[0], m[7:1]};
				toMem = 1'b1;
			end
			emx_pkg::OP_ROT_RIGHT_TO_ACC:
			begin
				result = {m[0], m[7:1]};
				toAcc = 1'b1;
			end
			emx_pkg::OP_ROT_RIGHT_CARRY_MEM,
			emx_pkg::OP_ROT_RIGHT_CARRY_TO_ACC:
			begin
				result = {flagsIn.carry, m[7:1]};
				toMem = (req.op == emx_pkg::OP_ROT_RIGHT_CARRY_MEM);
				toAcc = !toMem;
				flagsOut.carry = m[0];
			end
			emx_pkg::OP_SUB_BORROW_TO_ACC, emx_pkg::OP_SUB_BORROW_TO_MEM,
			emx_pkg::OP_SUB_TO_ACC, emx_pkg::OP_SUB_TO_MEM:
			begin
				result = diff9[7:0];
				toMem = (req.op == emx_pkg::OP_SUB_BORROW_TO_MEM) ||
					(req.op == emx_pkg::OP_SUB_TO_MEM);
				toAcc = !toMem;
				flagsOut.carry = diff9[8];
				flagsOut.auxCarry = low5[4];
				flagsOut.zero = (diff9[7:0] == 8'h00);
				flagsOut.overflow = ov;
				flagsOut.signedCompare = ov ^ diff9[7];
				// borrow chain keeps compare-zero across bytes
				flagsOut.compareZero = useBorrow ?
					(flagsOut.zero & flagsIn.compareZero) : flagsOut.zero;
			end
			emx_pkg::OP_DEC_SKIP_ZERO, emx_pkg::OP_DEC_SKIP_ZERO_TO_ACC:
			begin
				result = dec;
				toMem = (req.op == emx_pkg::OP_DEC_SKIP_ZERO);
				toAcc = !toMem;
				skip = (dec == 8'h00);
			end
			emx_pkg::OP_INC_SKIP_ZERO, emx_pkg::OP_INC_SKIP_ZERO_TO_ACC:
			begin
				result = inc;
				toMem = (req.op == emx_pkg::OP_INC_SKIP_ZERO);
				toAcc = !toMem;
				skip = (inc == 8'h00);
			end
			emx_pkg::OP_SET_MEM_BITS:
			begin
				result = `EMX_BYTE_ONES;
				toMem = 1'b1;
			end
			emx_pkg::OP_SET_MEM_BIT:
			begin
				result = m | bitMask(req.bitSel);
				toMem = 1'b1;
			end
			emx_pkg::OP_SKIP_NONZERO_BIT:
				skip = |(m & bitMask(req.bitSel));
			emx_pkg::OP_SKIP_NONZERO:
				skip = (m != 8'h00);
			emx_pkg::OP_NIBBLE_EXCHANGE, emx_pkg::OP_NIBBLE_EXCHANGE_TO_ACC:
			begin
				result = {m[3:0], m[7:4]};
				toMem = (req.op == emx_pkg::OP_NIBBLE_EXCHANGE);
				toAcc = !toMem;
			end
			emx_pkg::OP_SKIP_ZERO:
				skip = (m == 8'h00);
			emx_pkg::OP_MOVE_SKIP_ZERO:
			begin
				toAcc = 1'b1;
				skip = (m == 8'h00);
			end
			emx_pkg::OP_SKIP_ZERO_BIT:
				skip = !(|(m & bitMask(req.bitSel)));
			default:
				skip = 1'b0;
		endcase
	end

endmodule // emx_exec_unit

// file: emx_mem_model.sv
// data memory model beside the memory-op unit
`timescale 1ns/1ps

module emx_mem_model (
	input  wire logic       clk,    // core clock
	input  wire logic [7:0] rdAddr, // operand address
	output logic [7:0]      rdData, // operand byte
	input  wire logic       wrEn,   // write strobe
	input  wire logic [7:0] wrAddr, // write address
	input  wire logic [7:0] wrData  // write data
);
	logic [7:0] mem [256];

	// each byte starts equal to its address, so corners sit at known places
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0];
	end

	assign rdData = mem[rdAddr];

	always @(posedge clk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
	end
endmodule // emx_mem_model

// file: tb_top.sv
// self-checking bench of the memory-op unit
`timescale 1ns/1ps
`include "emx_regs.svh"

module tb_top;
	typedef struct packed {
		logic [7:0]          acc;
		emx_pkg::emx_flags_t fl;
		logic                wr;
		logic [7:0]          wd;
		logic                skip;
	} emx_exp_t;

	logic                clk, reset, opValid, opReady, opDone, skipTaken;
	logic                dummyCycle, memWrEn, awvalid, awready, wvalid;
	logic                wready, bvalid, bready, arvalid, arready, rvalid;
	logic                rready;
	emx_pkg::emx_op_t    opOp;
	emx_pkg::emx_req_t   opReq;
	emx_pkg::emx_flags_t flags, flM;
	logic [2:0]          opBit;
	logic [7:0]          opAddr, memWrAddr, memWrData, accumulator, memByte;
	logic [7:0]          awaddr, araddr, accM;
	logic [31:0]         wdata, rdata;
	logic [3:0]          wstrb;
	logic [1:0]          bresp, rresp;
	logic [15:0]         skipCnt;
	int                  errors, checkCount;
	logic [7:0]          corners [5] =
		'{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF};

	assign opReq = {opOp, opBit, memByte};

	emx_mem_op_exec #(.ADDR_W(8)) u_emx_mem_op_exec (.clk(clk),
		.reset(reset), .opValid(opValid), .opReq(opReq), .opAddr(opAddr),
		.opReady(opReady), .opDone(opDone), .skipTaken(skipTaken),
		.dummyCycle(dummyCycle), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
		.memWrData(memWrData), .accumulator(accumulator), .flags(flags),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	emx_mem_model u_emx_mem_model (.clk(clk), .rdAddr(opAddr),
		.rdData(memByte), .wrEn(memWrEn), .wrAddr(memWrAddr),
		.wrData(memWrData));

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d errors %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string msg);
		checkCount++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic tick(inout int n);
		@(posedge clk);
		n++;
		if (n > 20)
		begin
			errors++;
			$display("ERROR %0t wait limit", $time);
			end_sim();
		end
	endtask

	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic aw, w;
		int   n;
		awaddr  <= ad;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		aw = 0;
		w = 0;
		n = 0;
		while (!(aw && w))
		begin
			tick(n);
			if (!aw && awready === 1'b1)
			begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1)
			begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		n = 0;
		do
			tick(n);
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er, "bresp");
	endtask

	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] mask,
		input logic [31:0] exp, input logic [1:0] er);
		int n;
		araddr  <= ad;
		arvalid <= 1'b1;
		n = 0;
		do
			tick(n);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready  <= 1'b1;
		n = 0;
		do
			tick(n);
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata & mask, exp, "rdata");
		chk(rresp, er, "rresp");
	endtask

	task automatic set_regs(input logic [7:0] a, input logic [5:0] f);
		axi_wr(`EMX_OFS_ACC, {24'h0, a}, 4'hF, `EMX_RESP_OKAY);
		axi_wr(`EMX_OFS_FLAGS, {26'h0, f}, 4'hF, `EMX_RESP_OKAY);
		accM = a;
		flM = f;
	endtask

	////////////////////////////////////////////////////////////////////////
	function automatic emx_exp_t predict(emx_pkg::emx_op_t op,
		logic [2:0] b, logic [7:0] m, logic [7:0] a, emx_pkg::emx_flags_t f);
		emx_exp_t            e;
		emx_pkg::emx_flags_t sf;
		logic [8:0]          d;
		logic [4:0]          lo;
		logic                bor, nb;
		logic [7:0]          rr, rc, sw, dm, im;
		bor = op inside {emx_pkg::OP_SUB_BORROW_TO_ACC,
			emx_pkg::OP_SUB_BORROW_TO_MEM};
		nb = bor & ~f.carry;
		d = {1'b0, a} - {1'b0, m} - {8'h00, nb};
		lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, nb};
		sf.carry = ~d[8];
		sf.auxCarry = ~lo[4];
		sf.overflow = (a[7] ^ m[7]) & (a[7] ^ d[7]);
		sf.signedCompare = sf.overflow ^ d[7];
		sf.zero = d[7:0] == 8'h00;
		sf.compareZero = bor ? sf.zero & f.compareZero : sf.zero;
		rr = {m[0], m[7:1]};
		rc = {f.carry, m[7:1]};
		sw = {m[3:0], m[7:4]};
		dm = m - 8'h01;
		im = m + 8'h01;
		e = '{acc: a, fl: f, wr: 1'b1, wd: 8'h00, skip: 1'b0};
		case (op)
			emx_pkg::OP_ROT_LEFT_CARRY_TO_ACC: e.acc = {m[6:0], f.carry};
			emx_pkg::OP_ROT_RIGHT_TO_ACC: e.acc = rr;
			emx_pkg::OP_ROT_RIGHT_CARRY_TO_ACC: e.acc = rc;
			emx_pkg::OP_SUB_BORROW_TO_ACC, emx_pkg::OP_SUB_TO_ACC: e.acc = d[7:0];
			emx_pkg::OP_DEC_SKIP_ZERO_TO_ACC: e.acc = dm;
			emx_pkg::OP_INC_SKIP_ZERO_TO_ACC: e.acc = im;
			emx_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: e.acc = sw;
			emx_pkg::OP_MOVE_SKIP_ZERO: e.acc = m;
			default: e.acc = a;
		endcase
		case (op)
			emx_pkg::OP_ROT_RIGHT_MEM: e.wd = rr;
			emx_pkg::OP_ROT_RIGHT_CARRY_MEM: e.wd = rc;
			emx_pkg::OP_SUB_BORROW_TO_MEM, emx_pkg::OP_SUB_TO_MEM: e.wd = d[7:0];
			emx_pkg::OP_DEC_SKIP_ZERO: e.wd = dm;
			emx_pkg::OP_INC_SKIP_ZERO: e.wd = im;
			emx_pkg::OP_SET_MEM_BITS: e.wd = 8'hFF;
			emx_pkg::OP_SET_MEM_BIT: e.wd = m | (8'h01 << b);
			emx_pkg::OP_NIBBLE_EXCHANGE: e.wd = sw;
			default: e.wr = 1'b0;
		endcase
		case (op)
			emx_pkg::OP_DEC_SKIP_ZERO, emx_pkg::OP_DEC_SKIP_ZERO_TO_ACC:
				e.skip = dm == 8'h00;
			emx_pkg::OP_INC_SKIP_ZERO, emx_pkg::OP_INC_SKIP_ZERO_TO_ACC:
				e.skip = im == 8'h00;
			emx_pkg::OP_SKIP_NONZERO_BIT: e.skip = m[b];
			emx_pkg::OP_SKIP_NONZERO: e.skip = m != 8'h00;
			emx_pkg::OP_SKIP_ZERO, emx_pkg::OP_MOVE_SKIP_ZERO:
				e.skip = m == 8'h00;
			emx_pkg::OP_SKIP_ZERO_BIT: e.skip = !m[b];
			default: e.skip = 1'b0;
		endcase
		if (op == emx_pkg::OP_ROT_LEFT_CARRY_TO_ACC)
			e.fl.carry = m[7];
		if (op inside {emx_pkg::OP_ROT_RIGHT_CARRY_MEM,
			emx_pkg::OP_ROT_RIGHT_CARRY_TO_ACC})
			e.fl.carry = m[0];
		if (bor || op inside {emx_pkg::OP_SUB_TO_ACC, emx_pkg::OP_SUB_TO_MEM})
			e.fl = sf;
		return e;
	endfunction

	task automatic do_op(input int k, input logic [2:0] b, input logic [7:0] a);
		emx_exp_t e;
		opValid <= 1'b1;
		opOp    <= emx_pkg::emx_op_t'(k);
		opBit   <= b;
		opAddr  <= a;
		#1;
		e = predict(emx_pkg::emx_op_t'(k), b, memByte, accM, flM);
		@(posedge clk);
		opValid <= 1'b0;
		#1;
		chk(opDone, 1, "done");
		chk(accumulator, e.acc, "acc");
		chk(flags, e.fl, "flags");
		chk(memWrEn, e.wr, "wren");
		if (e.wr)
			chk({memWrAddr, memWrData}, {a, e.wd}, "wdata");
		chk(skipTaken, e.skip, "skip");
		chk({dummyCycle, opReady}, {e.skip, !e.skip}, "dummy");
		accM = e.acc;
		flM = e.fl;
		skipCnt += 16'(e.skip);
		@(posedge clk);
		if (e.skip)
		begin
			#1;
			chk({dummyCycle, opReady}, 2'b01, "resume");
			@(posedge clk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 0;
		reset = 1;
		errors = 0;
		checkCount = 0;
		skipCnt = 0;
		{opValid, opOp, opBit, opAddr} = '0;
		{awvalid, awaddr, wvalid, wdata, wstrb, bready} = '0;
		{arvalid, araddr, rready} = '0;
		void'($urandom(27));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd_chk(`EMX_OFS_ACC, 32'hFF, 32'h0, `EMX_RESP_OKAY);
		rd_chk(`EMX_OFS_FLAGS, 32'h3F, 32'h0, `EMX_RESP_OKAY);
		rd_chk(`EMX_OFS_SKIPS, 32'hFFFF, 32'h0, `EMX_RESP_OKAY);
		set_regs(8'h5A, 6'h2A);
		rd_chk(`EMX_OFS_ACC, 32'hFF, 32'h5A, `EMX_RESP_OKAY);
		rd_chk(`EMX_OFS_FLAGS, 32'h3F, 32'h2A, `EMX_RESP_OKAY);
		axi_wr(`EMX_OFS_ACC, 32'hA5, 4'hE, `EMX_RESP_OKAY);
		axi_wr(8'h0C, 32'h1, 4'hF, `EMX_RESP_SLVERR);
		axi_wr(`EMX_OFS_SKIPS, 32'hFFFF, 4'hF, `EMX_RESP_OKAY);
		rd_chk(`EMX_OFS_ACC, 32'hFF, 32'h5A, `EMX_RESP_OKAY);
		rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0, `EMX_RESP_SLVERR);
		rd_chk(`EMX_OFS_SKIPS, 32'hFFFF, 32'h0, `EMX_RESP_OKAY);
		// every op at addresses 00, 01, 7F, 80, FF; memory writes change those bytes along the way
		foreach (corners[j])
			for (int k = 0; k < 22; k++)
				do_op(k, 3'(k), corners[j]);
		for (int i = 0; i < 300; i++)
		begin
			if ($urandom_range(3) == 0)
				set_regs(8'($urandom), 6'($urandom));
			do_op($urandom_range(21), 3'($urandom), 8'($urandom));
		end
		rd_chk(`EMX_OFS_ACC, 32'hFF, {24'h0, accM}, `EMX_RESP_OKAY);
		rd_chk(`EMX_OFS_SKIPS, 32'hFFFF, {16'h0, skipCnt}, `EMX_RESP_OKAY);
		end_sim();
	end
endmodule // tb_top
